// file: design/scsi_msg_ctrl.sv
// Link-control message interpreter of a parallel SCSI target port.
//
// Functional notes
// - Reject unsupported message codes with MESSAGE REJECT.
// - IN goes target to initiator; OUT reversed.
// - Codes 80h to FFh decode as IDENTIFY.
// - DISCONNECT succeeds only without attention.
// - After successful DISCONNECT, release BSY.
// - Split transfer ends with SAVE POINTER, DISCONNECT.
// - Never send DISCONNECT under IU agreement.
// - Initiator DISCONNECT, no IU: send DISCONNECT, release.
// - Initiator DISCONNECT with IU: release BSY directly.
// - Hold off arbitration for longer delay.
// - Disabled or unable disconnect gets MESSAGE REJECT.
// - Identify: bit7 flag, bit6 privilege, low LUN.
// - Disconnect only when privilege bit granted.
// - Target-sent IDENTIFY has privilege bit zero.
// - No privilege, pending reconnect needed: BUSY status.
// - Different LUN before bus free: unexpected free.
// - Connection identify succeeds when first in phase and no error seen.
// - Reselect identify succeeds without attention.
// - Code 01h starts extended message; its length byte counts the rest.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns

module scsi_msg_ctrl
    import scsi_msg_pkg::*;
#(
    parameter int DISC_DELAY_NS = 200000
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Message out bytes from the phase logic.
    input wire logic mout_valid_i,
    input wire logic [7:0] mout_byte_i,
    input wire logic mout_err_i,
    input wire logic mout_first_i,
    // Message in bytes to the phase logic.
    output logic min_valid_o,
    output logic [7:0] min_byte_o,
    input wire logic min_ready_i,
    input wire logic min_atn_i,
    // Bus phase events.
    input wire logic bus_free_i,
    output logic bsy_release_o,
    output logic unexpected_free_o,
    output logic busy_status_o,
    output logic arb_inhibit_o
);

    // Least disconnection delay in clock cycles, rounded up.
    localparam int DISC_DELAY_CYC =
        (DISC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    cfg_t cfg; // Configuration bits from the control register.
    logic [31:0] limit; // Physical disconnect time limit in cycles.
    msg_state_t state; // Interpreter state.
    logic [31:0] hold_cnt; // Arbitration hold-off counter.
    logic ext_len_next; // Next byte is an extended length.
    logic [8:0] ext_left; // Extended bytes still to come.
    logic nexus; // An IDENTIFY has fixed the LUN.
    logic [LUN_W-1:0] lun; // Latched logical unit number.
    logic priv; // Disconnect privilege of the current task.
    logic ident_ok; // Identification succeeded.
    logic disc_fail; // Last DISCONNECT met an attention condition.
    logic [7:0] last_msg; // Last message byte received.
    logic pend_disc; // Software asked for a split disconnect.
    logic pend_ident; // Software asked for a reselect IDENTIFY.
    logic aw_hold; // Write address captured.
    logic w_hold; // Write data captured.
    logic [7:0] aw_addr; // Captured write address.
    logic [31:0] w_data; // Captured write data.
    logic [3:0] w_strb; // Captured write strobes.
    logic do_write; // Both halves of a write present.
    logic cmd_disc; // Disconnect command written this cycle.
    logic cmd_ident; // Identify command written this cycle.
    logic in_taken; // Message-in byte accepted this cycle.
    logic [31:0] hold_len; // Longer of the two hold-off times.
    logic is_ident; // Received byte is an IDENTIFY.
    logic byte_free; // Received byte is a message start.

    // Write channel: each half is taken alone, both answered together.
    assign s_axi_awready_o = !aw_hold && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_hold && !s_axi_bvalid_o;
    assign do_write = aw_hold && w_hold && !s_axi_bvalid_o;
    assign cmd_disc = do_write && aw_addr == CMD_OFS && w_strb[0]
        && w_data[CMD_DISC_BIT];
    assign cmd_ident = do_write && aw_addr == CMD_OFS && w_strb[0]
        && w_data[CMD_IDENT_BIT];
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign in_taken = min_valid_o && min_ready_i;
    assign hold_len = (limit > 32'(DISC_DELAY_CYC)) ?
        limit : 32'(DISC_DELAY_CYC);
    assign is_ident = mout_byte_i[ID_FLAG_BIT];
    assign byte_free = !ext_len_next && ext_left == 9'h000;
    assign arb_inhibit_o = state == ST_HOLDOFF;

    // Capture of write address and data and the write response.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else begin
            // Address and data may arrive in either order.
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            // Answer once both halves are present.
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                case (aw_addr)
                    CTRL_OFS, LIMIT_OFS, CMD_OFS: begin
                        s_axi_bresp_o <= RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp_o <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            cfg <= CTRL_RESET;
            limit <= LIMIT_RESET;
        end else if (do_write) begin
            if (aw_addr == CTRL_OFS && w_strb[0]) begin
                cfg <= w_data[4:0];
            end
            if (aw_addr == LIMIT_OFS) begin
                // Each enabled byte lane updates its own byte.
                for (int i = 0; i < 4; i++) begin
                    if (w_strb[i]) begin
                        limit[8*i +: 8] <= w_data[8*i +: 8];
                    end
                end
            end
        end
    end

    // Read channel: one word answered the cycle after the address.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= RESP_OKAY;
            s_axi_rdata_o <= 32'h00000000;
            case (s_axi_araddr_i)
                CTRL_OFS: begin
                    s_axi_rdata_o <= {27'h0000000, cfg};
                end
                LIMIT_OFS: begin
                    s_axi_rdata_o <= limit;
                end
                STATUS_OFS: begin
                    // State of the nexus and the last disconnect.
                    s_axi_rdata_o[ST_NEXUS_BIT] <= nexus;
                    s_axi_rdata_o[ST_PRIV_BIT] <= priv;
                    s_axi_rdata_o[ST_IDOK_BIT] <= ident_ok;
                    s_axi_rdata_o[ST_DFAIL_BIT] <= disc_fail;
                    s_axi_rdata_o[ST_HOLD_BIT] <= arb_inhibit_o;
                    s_axi_rdata_o[ST_LUN_LSB +: LUN_W] <= lun;
                end
                CMD_OFS: begin
                    // Command bits read back as pending requests.
                    s_axi_rdata_o[CMD_DISC_BIT] <= pend_disc;
                    s_axi_rdata_o[CMD_IDENT_BIT] <= pend_ident;
                end
                LAST_MSG_OFS: begin
                    s_axi_rdata_o <= {24'h000000, last_msg};
                end
                default: begin
                    s_axi_rresp_o <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // Software commands stay pending until the interpreter takes them.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pend_disc <= 1'b0;
            pend_ident <= 1'b0;
        end else begin
            // A new command wins over the clear in the same cycle.
            if (cmd_disc) begin
                pend_disc <= 1'b1;
            end else if (state == ST_IDLE && !mout_valid_i) begin
                pend_disc <= 1'b0;
            end
            if (cmd_ident) begin
                pend_ident <= 1'b1;
            end else if (state == ST_IDLE && !mout_valid_i
                && !pend_disc) begin
                pend_ident <= 1'b0;
            end
        end
    end

    // Framing of extended messages so their bytes are not decoded.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ext_len_next <= 1'b0;
            ext_left <= 9'h000;
        end else if (bus_free_i) begin
            ext_len_next <= 1'b0;
            ext_left <= 9'h000;
        end else if (mout_valid_i && state == ST_IDLE) begin
            if (ext_len_next) begin
                // A length of zero means 256 bytes follow.
                ext_len_next <= 1'b0;
                ext_left <= (mout_byte_i == 8'h00) ?
                    9'h100 : {1'b0, mout_byte_i};
            end else if (ext_left != 9'h000) begin
                ext_left <= ext_left - 9'h001;
            end else if (mout_byte_i == MSG_EXTENDED) begin
                ext_len_next <= 1'b1;
            end
        end
    end

    // Nexus tracking: LUN, privilege and identification result.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            nexus <= 1'b0;
            lun <= '0;
            priv <= 1'b0;
            ident_ok <= 1'b0;
            last_msg <= 8'h00;
        end else if (bus_free_i || state == ST_RELEASE) begin
            nexus <= 1'b0;
            ident_ok <= 1'b0;
        end else if (mout_valid_i && state == ST_IDLE) begin
            last_msg <= mout_byte_i;
            if (mout_err_i) begin
                // Any error on IDENTIFY or task attribute fails it.
                ident_ok <= 1'b0;
            end else if (byte_free && is_ident) begin
                // The first IDENTIFY fixes the LUN for the connection.
                if (!nexus) begin
                    nexus <= 1'b1;
                    lun <= mout_byte_i[LUN_W-1:0];
                    ident_ok <= mout_first_i;
                end
                priv <= mout_byte_i[ID_PRIV_BIT];
            end
        end else if (state == ST_SEND_IDENT && in_taken) begin
            // Reselect identification fails on an attention.
            nexus <= 1'b1;
            priv <= 1'b0;
            ident_ok <= !min_atn_i;
        end
    end

    // Message interpreter and message-in byte source.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
            min_valid_o <= 1'b0;
            min_byte_o <= 8'h00;
            bsy_release_o <= 1'b0;
            unexpected_free_o <= 1'b0;
            busy_status_o <= 1'b0;
            disc_fail <= 1'b0;
        end else begin
            bsy_release_o <= 1'b0;
            unexpected_free_o <= 1'b0;
            busy_status_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (mout_valid_i && !mout_err_i) begin
                        if (!byte_free) begin
                            // Last extended byte: rejected, negotiated elsewhere.
                            if (!ext_len_next && ext_left == 9'h001) begin
                                state <= ST_SEND_REJ;
                                min_valid_o <= 1'b1;
                                min_byte_o <= MSG_REJECT;
                            end
                        end else if (is_ident) begin
                            if (nexus && mout_byte_i[LUN_W-1:0] != lun) begin
                                // LUN changed before bus free.
                                unexpected_free_o <= 1'b1;
                            end else if (!mout_byte_i[ID_PRIV_BIT]
                                && cfg.pending_tasks
                                && cfg.reconnect_needed) begin
                                busy_status_o <= 1'b1;
                            end
                        end else if (mout_byte_i == MSG_DISCONNECT) begin
                            // Initiator asks for a physical disconnect.
                            if (!cfg.disc_enable || !cfg.can_disconnect
                                || !priv) begin
                                state <= ST_SEND_REJ;
                                min_valid_o <= 1'b1;
                                min_byte_o <= MSG_REJECT;
                            end else if (cfg.iu_agreement) begin
                                state <= ST_RELEASE;
                            end else begin
                                state <= ST_SEND_DISC;
                                min_valid_o <= 1'b1;
                                min_byte_o <= MSG_DISCONNECT;
                            end
                        end else if (mout_byte_i != MSG_INIT_ERR
                            && mout_byte_i != MSG_REJECT
                            && mout_byte_i != MSG_NOP
                            && mout_byte_i != MSG_PARITY_ERR
                            && mout_byte_i != MSG_EXTENDED) begin
                            state <= ST_SEND_REJ;
                            min_valid_o <= 1'b1;
                            min_byte_o <= MSG_REJECT;
                        end
                    end else if (!mout_valid_i && pend_disc) begin
                        // Split transfer: save pointer, then disconnect.
                        if (!cfg.iu_agreement && priv) begin
                            state <= ST_SEND_SDP;
                            min_valid_o <= 1'b1;
                            min_byte_o <= MSG_SAVE_PTR;
                        end
                    end else if (!mout_valid_i && pend_ident) begin
                        state <= ST_SEND_IDENT;
                        min_valid_o <= 1'b1;
                        min_byte_o <= {1'b1, 1'b0, 6'(lun)};
                    end
                end
                ST_SEND_SDP: begin
                    if (in_taken) begin
                        state <= ST_SEND_DISC;
                        min_byte_o <= MSG_DISCONNECT;
                    end
                end
                ST_SEND_DISC: begin
                    if (in_taken) begin
                        min_valid_o <= 1'b0;
                        disc_fail <= min_atn_i;
                        // Attention on the byte keeps the connection.
                        state <= min_atn_i ? ST_IDLE : ST_RELEASE;
                    end
                end
                ST_SEND_REJ, ST_SEND_IDENT: begin
                    if (in_taken) begin
                        min_valid_o <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                ST_RELEASE: begin
                    bsy_release_o <= 1'b1;
                    state <= ST_HOLDOFF;
                end
                ST_HOLDOFF: begin
                    if (hold_cnt <= 32'h00000001) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    min_valid_o <= 1'b0;
                end
            endcase
        end
    end

    // Hold-off counter loaded when BSY is released.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hold_cnt <= 32'h00000000;
        end else if (state == ST_RELEASE) begin
            hold_cnt <= hold_len;
        end else if (hold_cnt != 32'h00000000) begin
            hold_cnt <= hold_cnt - 32'h00000001;
        end
    end

endmodule : scsi_msg_ctrl

// file: design/scsi_msg_pkg.sv
// Constants, types and register map of the link-control message block.
package scsi_msg_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] LIMIT_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] CMD_OFS = 8'h0C;
    localparam logic [7:0] LAST_MSG_OFS = 8'h10;

    // Reset values of the writable registers.
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [31:0] LIMIT_RESET = 32'h00000000;

    // Command register bit positions.
    localparam int CMD_DISC_BIT = 0;
    localparam int CMD_IDENT_BIT = 1;

    // Status register field positions.
    localparam int ST_NEXUS_BIT = 0;
    localparam int ST_PRIV_BIT = 1;
    localparam int ST_IDOK_BIT = 2;
    localparam int ST_DFAIL_BIT = 3;
    localparam int ST_HOLD_BIT = 4;
    localparam int ST_LUN_LSB = 8;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Message codes handled by the interpreter.
    localparam logic [7:0] MSG_EXTENDED = 8'h01;
    localparam logic [7:0] MSG_SAVE_PTR = 8'h02;
    localparam logic [7:0] MSG_DISCONNECT = 8'h04;
    localparam logic [7:0] MSG_INIT_ERR = 8'h05;
    localparam logic [7:0] MSG_REJECT = 8'h07;
    localparam logic [7:0] MSG_NOP = 8'h08;
    localparam logic [7:0] MSG_PARITY_ERR = 8'h09;

    // Identify byte layout.
    localparam int ID_FLAG_BIT = 7;
    localparam int ID_PRIV_BIT = 6;
    localparam int LUN_W = 6;

    // Timing.
    localparam int CLK_PERIOD_NS = 10;

    // Configuration bits held in the control register.
    typedef struct packed {
        logic reconnect_needed;
        logic pending_tasks;
        logic can_disconnect;
        logic iu_agreement;
        logic disc_enable;
    } cfg_t;

    // Interpreter states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEND_SDP,
        ST_SEND_DISC,
        ST_SEND_REJ,
        ST_SEND_IDENT,
        ST_RELEASE,
        ST_HOLDOFF
    } msg_state_t;

endpackage : scsi_msg_pkg

// file: test/scsi_msg_ctrl_props.sv
// Port checker for the link-control message interpreter.
`timescale 1ns/1ns
module scsi_msg_ctrl_props (
    // Clock, reset and watched ports.
    input wire logic clk_sys_i, reset_i,
    input wire logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o,
    input wire logic s_axi_rready_i, s_axi_bvalid_o, s_axi_bready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic mout_valid_i, mout_err_i, min_valid_o,
    input wire logic [7:0] mout_byte_i, min_byte_o,
    input wire logic min_ready_i, min_atn_i, bsy_release_o, arb_inhibit_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // A message byte stands until the phase logic takes it.
    property p_min_hold;
        min_valid_o && !min_ready_i |=> min_valid_o && $stable(min_byte_o);
    endproperty
    a_min_hold: assert property (p_min_hold) else $error("min byte moved");
    property p_b_hold;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
            && $stable(s_axi_bresp_o);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp moved");
    property p_r_hold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
            && $stable(s_axi_rdata_o);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata moved");
    property p_r_ans;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
    endproperty
    a_r_ans: assert property (p_r_ans) else $error("read late");
    // A target-sent identify never grants privilege.
    property p_tgt_ident;
        min_valid_o && min_byte_o[7] |-> !min_byte_o[6];
    endproperty
    a_tgt_ident: assert property (p_tgt_ident) else $error("priv set");
    property p_inhibit;
        bsy_release_o |=> arb_inhibit_o;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("no holdoff");
    // Attention on the disconnect byte keeps BSY held.
    property p_disc_atn;
        min_valid_o && min_ready_i && min_atn_i && min_byte_o == 8'h04
            |=> !bsy_release_o [*2];
    endproperty
    a_disc_atn: assert property (p_disc_atn) else $error("bad free");
    property p_disc_ok;
        min_valid_o && min_ready_i && !min_atn_i && min_byte_o == 8'h04
            |-> ##[1:2] bsy_release_o;
    endproperty
    a_disc_ok: assert property (p_disc_ok) else $error("no free");
    property p_reject;
        mout_valid_i && !mout_err_i && mout_byte_i == 8'h30 && !min_valid_o
            && !arb_inhibit_o |-> ##[1:3] (min_valid_o && min_byte_o == 8'h07);
    endproperty
    a_reject: assert property (p_reject) else $error("no reject");
    c_free: cover property (bsy_release_o);
    c_rej: cover property (min_valid_o && min_byte_o == 8'h07);
    c_inh: cover property (arb_inhibit_o);
endmodule : scsi_msg_ctrl_props
bind scsi_msg_ctrl scsi_msg_ctrl_props scsi_msg_ctrl_props_inst (.*);

// file: test/scsi_initiator_model.sv
// Initiator-side model that takes MESSAGE IN bytes after a stall.
`timescale 1ns/1ns
module scsi_initiator_model (
    // Clock and message in handshake.
    input wire logic clk_sys_i,
    input wire logic min_valid_i, atn_i,
    input wire logic [7:0] min_byte_i,
    output logic min_ready_o, min_atn_o,
    output logic [7:0] last_o,
    output int cnt_o
);
    int stall = 0; // Cycles waited on the current byte.
    // Attention rides only on the byte being taken; it is dropped otherwise.
    assign min_atn_o = atn_i && min_ready_o;
    // Bytes travel target to initiator; pointers are left untouched.
    initial begin
        min_ready_o = 0;
        last_o = 8'h00;
        cnt_o = 0;
    end
    always @(posedge clk_sys_i) begin
        if (min_valid_i && !min_ready_o && stall == 2) begin
            min_ready_o <= 1;
            last_o <= min_byte_i;
            cnt_o <= cnt_o + 1;
        end else begin
            min_ready_o <= 0;
            stall <= (min_valid_i && !min_ready_o) ? stall + 1 : 0;
        end
    end
endmodule : scsi_initiator_model

// file: test/test_scsi_msg_ctrl.sv
// Register and message sequence bench for the message interpreter.
`timescale 1ns/1ns
module test_scsi_msg_ctrl;
    import scsi_msg_pkg::*;
    logic clk_sys_i = 0, reset_i = 1; // Clock and reset.
    logic [7:0] awaddr = 0, araddr = 0, mbyte = 0, minb, last; // Bytes.
    logic [31:0] wdata = 0, rd, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic mvalid = 0, mfirst = 0, bfree = 0, atn = 0, merr = 0, uf, busy, inh;
    logic awready, wready, bvalid, arready, rvalid, minv, mrdy, matn, rel;
    logic [1:0] bresp, rresp, rr;
    int pcnt, c0, nrel = 0, nuf = 0, nbusy = 0, ninh = 0;
    int fail_count = 0, check_count = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    scsi_msg_ctrl #(.DISC_DELAY_NS(100)) scsi_msg_ctrl_inst (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .mout_valid_i(mvalid),
        .mout_byte_i(mbyte), .mout_err_i(merr), .mout_first_i(mfirst),
        .min_valid_o(minv), .min_byte_o(minb), .min_ready_i(mrdy),
        .min_atn_i(matn), .bus_free_i(bfree), .bsy_release_o(rel),
        .unexpected_free_o(uf), .busy_status_o(busy), .arb_inhibit_o(inh));
    scsi_initiator_model scsi_initiator_model_inst (.clk_sys_i(clk_sys_i),
        .min_valid_i(minv), .atn_i(atn), .min_byte_i(minb),
        .min_ready_o(mrdy), .min_atn_o(matn), .last_o(last), .cnt_o(pcnt));
    // Pulse and level counters on the bus-phase outputs.
    always @(posedge clk_sys_i) begin
        nrel <= nrel + (rel === 1'b1);
        nuf <= nuf + (uf === 1'b1);
        nbusy <= nbusy + (busy === 1'b1);
        ninh <= ninh + (inh === 1'b1);
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge clk_sys_i);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        @(posedge clk_sys_i);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge clk_sys_i);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        {rd, rr} = {rdata, rresp};
        rready <= 0;
    endtask : axr
    // One message out byte, then time for the answer and any holdoff.
    task automatic msg(input logic [7:0] b, input logic f);
        @(posedge clk_sys_i);
        {mbyte, mfirst, mvalid} <= {b, f, 1'b1};
        @(posedge clk_sys_i);
        mvalid <= 0;
        repeat (50) @(posedge clk_sys_i);
    endtask : msg
    task automatic free();
        @(posedge clk_sys_i);
        bfree <= 1;
        @(posedge clk_sys_i);
        bfree <= 0;
    endtask : free
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    initial begin
        #50us;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 0;
        axr(CTRL_OFS); chk("ctrl", rd, 32'h00000000);
        axr(STATUS_OFS); chk("status", rd, 32'h00000000);
        axr(8'h20); chk("unmapped", rr, RESP_SLVERR);
        axw(8'h20, 32'h00000001); chk("wr unmapped", bresp, RESP_SLVERR);
        msg(8'h85, 1); axr(STATUS_OFS); chk("ident", rd, 32'h00000505);
        msg(8'h86, 0); chk("lun change", nuf, 1);
        free(); axw(LIMIT_OFS, 32'h0000001E); axw(CTRL_OFS, 32'h00000005);
        msg(8'hC3, 1); msg(MSG_DISCONNECT, 0);
        chk("disc byte", last, MSG_DISCONNECT);
        chk("release", nrel, 1); chk("holdoff", ninh, 30);
        free(); atn <= 1; msg(8'hC3, 1); msg(MSG_DISCONNECT, 0); atn <= 0;
        chk("atn release", nrel, 1); axr(STATUS_OFS);
        chk("disc fail", rd[ST_DFAIL_BIT], 1'b1); c0 = pcnt;
        axw(CMD_OFS, 32'h00000001); repeat (60) @(posedge clk_sys_i);
        chk("split", pcnt, c0 + 2); chk("split free", nrel, 2);
        axw(CTRL_OFS, 32'h00000000); msg(MSG_DISCONNECT, 0);
        chk("disabled", last, MSG_REJECT); c0 = pcnt;
        msg(8'h30, 0); chk("unsupported", pcnt, c0 + 1);
        free(); axw(CTRL_OFS, 32'h00000007); msg(8'hC3, 1);
        c0 = pcnt; msg(MSG_DISCONNECT, 0);
        chk("iu release", nrel, 3); chk("iu silent", pcnt, c0);
        free(); axw(CTRL_OFS, 32'h00000018); msg(8'h80, 1);
        chk("busy", nbusy, 1);
        axw(CMD_OFS, 32'h00000002); repeat (20) @(posedge clk_sys_i);
        chk("tgt ident", last, 8'h80);
        axr(STATUS_OFS); chk("resel id", rd[ST_IDOK_BIT], 1'b1);
        merr <= 1; msg(8'h81, 1); merr <= 0; axr(STATUS_OFS); c0 = pcnt;
        chk("id err", rd[ST_IDOK_BIT], 1'b0);
        msg(MSG_EXTENDED, 0); msg(8'h02, 0); msg(8'h03, 0); msg(8'h01, 0);
        chk("ext reject", pcnt, c0 + 1);
        end_sim();
    end
endmodule : test_scsi_msg_ctrl
